// ==== logic/dsl_frame_mux_demux.v ====
`include "frame_defines.vh"
module dsl_frame_mux_demux (
  input  wire                 mclk,
  input  wire                 rst_n,
  input  wire                 two_pair,
  input  wire                 customer_side,
  input  wire                 bit_en,
  input  wire                 core_bit,
  output wire                 core_ready,
  input  wire [`AUX_COUNT-1:0] aux_tx,
  input  wire [45:0]          oh_tx,
  input  wire signed [7:0]    phase_err,
  output reg                  tx_bit,
  output reg                  tx_frame_start,
  input  wire                 rx_line_bit,
  input  wire                 rx_bit_en,
  output reg                  rx_core_bit,
  output reg                  rx_core_valid,
  output reg                  rx_aux_bit,
  output reg                  rx_aux_valid,
  output reg [5:0]            rx_aux_index,
  output reg                  rx_oh_bit,
  output reg                  rx_oh_valid,
  output reg [5:0]            rx_oh_index,
  output reg [`CNT_W-1:0]     rx_frame_len,
  output reg                  rx_len_valid
);
  // ---------------------------------------------------------------
  // Bit position decode shared by both directions.
  // ---------------------------------------------------------------
  localparam [1:0] K_SYNC = 2'd0;
  localparam [1:0] K_OH   = 2'd1;
  localparam [1:0] K_AUX  = 2'd2;
  localparam [1:0] K_CORE = 2'd3;
  // Both directions use the same decoder, so layout never differs.
  function [15:0] classify;
    input [`CNT_W-1:0] pos;
    input              tp;
    reg   [`CNT_W-1:0] blen;
    reg   [`CNT_W-1:0] gpay;
    reg   [`CNT_W-1:0] off;
    reg   [2:0]        g;
    begin
      blen = tp ? 14'd`BLOCK_LEN_2P : 14'd`BLOCK_LEN_1P; // RULE_02 RULE_21
      gpay = blen * 14'd`BLOCKS_PER_GROUP;
      off  = pos - 14'd`SYNC_LEN - 14'd`OH_FIRST;
      g    = 3'd0;
      classify = 16'h0000;
      if (pos < 14'd`SYNC_LEN) begin
        classify = {K_SYNC, 8'h00, pos[5:0]}; // RULE_01 RULE_13
      end else if (pos < 14'd`SYNC_LEN + 14'd`OH_FIRST) begin
        classify = {K_OH, 8'h00, pos[5:0]};
      end else begin
        if (off >= gpay) begin
          off = off - gpay;
          g   = 3'd1; // RULE_06
        end
        classify = decode_rest(off, g, blen, gpay);
      end
    end
  endfunction
  // Resolves overhead, auxiliary and core positions after the two overhead bits of group one.
  function [15:0] decode_rest;
    input [`CNT_W-1:0] off_in;
    input [2:0]        g_in;
    input [`CNT_W-1:0] blen;
    input [`CNT_W-1:0] gpay;
    reg   [`CNT_W-1:0] off;
    reg   [2:0]        g;
    reg   [`CNT_W-1:0] inb;
    reg   [5:0]        blk;
    reg   [5:0]        ohn;
    integer            i;
    begin
      off = off_in;
      g   = 3'd0;
      decode_rest = 16'h0000;
      if (g_in != 3'd0) begin
        g = 3'd1;
        for (i = 0; i < 3; i = i + 1) begin
          if (g != 3'd4 && off >= 14'd`OH_GROUP + gpay) begin
            off = off - (14'd`OH_GROUP + gpay);
            g = g + 3'd1;
          end
        end
      end
      if (g == 3'd4) begin
        decode_rest = {K_OH, 8'h00, 6'd46 + off[5:0]}; // RULE_07 RULE_17
      end else if (g != 3'd0 && off < `OH_GROUP) begin
        ohn = 6'd16 + {g - 3'd1, 3'd0} + {2'd0, g - 3'd1, 1'b0} + off[5:0];
        decode_rest = {K_OH, 8'h00, ohn}; // RULE_14 RULE_16 RULE_18
      end else begin
        if (g != 3'd0) off = off - 14'd`OH_GROUP;
        blk = 6'd0;
        inb = off;
        for (i = 0; i < `BLOCKS_PER_GROUP - 1; i = i + 1) begin
          if (inb >= blen) begin
            inb = inb - blen;
            blk = blk + 6'd1;
          end
        end
        blk = blk + {g[1:0], 3'd0} + {1'b0, g[1:0], 2'd0};
        if (inb == 0)
          decode_rest = {K_AUX, 8'h00, blk}; // RULE_03
        else
          decode_rest = {K_CORE, 8'h00, blk};
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Stuffing decision with a dead band.
  // ---------------------------------------------------------------
  // Phase error is in unit intervals at the tributary rate; the dead band keeps
  // small wander from toggling the stuffing length every frame.
  reg [2:0] stuff_bits;
  wire [2:0] next_stuff =
    (phase_err >  $signed(8'd`PHASE_UI)) ? 3'd4 :
    (phase_err < -$signed(8'd`PHASE_UI)) ? 3'd0 : 3'd2; // RULE_08 RULE_20

  wire [`CNT_W-1:0] body_len = two_pair ? (14'd`FRAME_NOM_2P - 14'd2)
                                        : (14'd`FRAME_NOM_1P - 14'd2);
  wire [`CNT_W-1:0] tx_len   = body_len + {11'd0, stuff_bits}; // RULE_09

  // ---------------------------------------------------------------
  // Transmit multiplexer.
  // ---------------------------------------------------------------
  reg  [`CNT_W-1:0] tx_pos;
  wire [15:0]       tx_cls  = classify(tx_pos, two_pair);
  localparam [`SYNC_LEN-1:0] SYNC_PATTERN = `SYNC_WORD;
  wire [1:0]        tx_kind = tx_cls[15:14];
  wire [5:0]        tx_idx  = tx_cls[5:0];
  assign core_ready = bit_en && tx_kind == K_CORE;
  // Power status is unassigned outside the customer-to-exchange direction.
  wire ps_slot = (tx_idx == 6'd22) || (tx_idx == 6'd23);
  wire oh_val  = (ps_slot && !customer_side) ? 1'b1 : oh_tx[tx_idx]; // RULE_11 RULE_15
  reg next_tx_bit;
  always @* begin
    case (tx_kind)
      K_SYNC:  next_tx_bit = SYNC_PATTERN[`SYNC_LEN - 1 - tx_idx];
      K_OH:    next_tx_bit = (tx_idx >= 6'd46) ? 1'b1 : oh_val;
      K_AUX:   next_tx_bit = (tx_idx < `AUX_RESERVED) ? 1'b1 : aux_tx[tx_idx]; // RULE_04 RULE_05
      default: next_tx_bit = core_bit;
    endcase
  end
  always @(posedge mclk) begin
    if (!rst_n) begin
      tx_pos         <= {`CNT_W{1'b0}};
      tx_bit         <= 1'b1;
      tx_frame_start <= 1'b0;
      stuff_bits     <= 3'd2;
    end else begin
      tx_frame_start <= 1'b0;
      if (bit_en) begin
        tx_bit <= next_tx_bit; // RULE_19 RULE_12
        if (tx_pos == tx_len - 14'd1) begin
          tx_pos     <= {`CNT_W{1'b0}};
          stuff_bits <= next_stuff; // RULE_07
          tx_frame_start <= 1'b1;
        end else begin
          tx_pos <= tx_pos + 14'd1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive demultiplexer.
  // ---------------------------------------------------------------
  reg rx_m1, rx_s, en_m1, en_s, en_d;
  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_m1 <= 1'b0;
      rx_s  <= 1'b0;
      en_m1 <= 1'b0;
      en_s  <= 1'b0;
      en_d  <= 1'b0;
    end else begin
      rx_m1 <= rx_line_bit;
      rx_s  <= rx_m1;
      en_m1 <= rx_bit_en;
      en_s  <= en_m1;
      en_d  <= en_s;
    end
  end
  wire rx_take = en_s && !en_d;
  wire sync_hit;
  frame_sync_finder u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .bit_en   (rx_take),
    .bit_in   (rx_s),
    .sync_hit (sync_hit)
  );
  // Bits are delayed by the sync length so the frame decoded is the one
  // whose start has just been located by its own sync word.
  reg [`CNT_W-1:0] rx_pos;
  reg [`CNT_W-1:0] rx_count;
  reg [`SYNC_LEN-1:0] rx_hist;
  // Nothing is reported until a first sync word has aligned the position count.
  reg                 rx_locked;
  wire [15:0] rx_cls = classify(rx_pos, two_pair);
  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_pos <= {`CNT_W{1'b0}};
      rx_count <= {`CNT_W{1'b0}};
      rx_hist <= {`SYNC_LEN{1'b0}};
      rx_locked <= 1'b0;
      rx_frame_len <= {`CNT_W{1'b0}};
      rx_len_valid <= 1'b0;
      rx_core_bit <= 1'b0;
      rx_core_valid <= 1'b0;
      rx_aux_bit <= 1'b0;
      rx_aux_valid <= 1'b0;
      rx_aux_index <= 6'd0;
      rx_oh_bit <= 1'b0;
      rx_oh_valid <= 1'b0;
      rx_oh_index <= 6'd0;
    end else begin
      rx_core_valid <= 1'b0;
      rx_aux_valid <= 1'b0;
      rx_oh_valid <= 1'b0;
      rx_len_valid <= 1'b0;
      if (rx_take) begin
        rx_hist <= {rx_hist[`SYNC_LEN-2:0], rx_s};
        rx_count <= rx_count + 14'd1;
        rx_pos <= rx_pos + 14'd1;
        case (rx_locked ? rx_cls[15:14] : K_SYNC)
          K_CORE: begin
            rx_core_bit <= rx_hist[`SYNC_LEN-1];
            rx_core_valid <= 1'b1;
          end
          K_AUX: begin
            rx_aux_bit <= rx_hist[`SYNC_LEN-1];
            rx_aux_valid <= 1'b1;
            rx_aux_index <= rx_cls[5:0];
          end
          K_OH: begin
            rx_oh_bit <= rx_hist[`SYNC_LEN-1];
            rx_oh_valid <= (rx_cls[5:0] < 6'd46);
            rx_oh_index <= rx_cls[5:0];
          end
          default: begin
          end
        endcase
      end
      if (sync_hit) begin
        rx_frame_len <= rx_count; // RULE_10
        rx_len_valid <= rx_locked;
        rx_locked <= 1'b1;
        rx_count <= {`CNT_W{1'b0}};
        rx_pos <= {`CNT_W{1'b0}};
      end
    end
  end
endmodule

// ==== logic/frame_defines.vh ====
// How it works
// (RULE_01) Frame has four groups; group one opens with 14-bit sync word, two overhead bits.
// (RULE_02) One-pair payload block is 289 bits: one auxiliary bit, thirty-six core bytes.
// (RULE_03) Auxiliary bits 1 to 48, one per block, form an 8 kbit/s channel.
// (RULE_04) Transmitter forces auxiliary bits 1 through 8 to one.
// (RULE_05) Auxiliary bits 9 to 48 pass transparently; unused ones are sent as one.
// (RULE_06) Groups two to four hold ten overhead bits then twelve payload blocks.
// (RULE_07) Four stuffing slots at frame end; normally one pair, omitted or doubled by phase.
// (RULE_08) Stuffing decision has a dead band of at least 2 unit intervals.
// (RULE_09) One-pair frame is 13920 bits nominal, 13922 or 13918 with stuffing.
// (RULE_10) Receiver measures frame length by finding next sync word, then adapts.
// (RULE_11) Same layout both directions; unassigned bits are sent as one.
// (RULE_12) Every pair uses an identical bit assignment.
// (RULE_13) Two-pair: bits 1-14 sync, 15 loss indicator, 16 block error, blocks at 17-1756.
// (RULE_14) Two-pair bits 1757-1766 carry channel address, opcode, byte, CRC, power, violation.
// (RULE_15) Power status bits only meaningful from customer side; else sent as one.
// (RULE_16) Two-pair bits 3507-3516 carry message 1-4, CRC 3-4, regenerator flags.
// (RULE_17) Two-pair blocks at 1767-3506, 3517-5256, 5267-7006; stuffing at 7007-7010.
// (RULE_18) Two-pair bits 5257-5266 carry message 5-8, CRC 5-6, alarm, ready, indicators.
// (RULE_19) Every frame bit including sync and stuffing goes to the scrambler.
// (RULE_20) Two-pair stuffing insertions and removals are identical on both pairs.
// (RULE_21) Two-pair payload block is 145 bits: one auxiliary bit, eighteen core bytes.
`ifndef FRAME_DEFINES_VH
`define FRAME_DEFINES_VH
`define SYNC_LEN         14
`define SYNC_WORD        14'h3CF0
`define OH_FIRST         2
`define OH_GROUP         10
`define BLOCKS_PER_GROUP 12
`define BLOCK_LEN_1P     289
`define BLOCK_LEN_2P     145
`define AUX_RESERVED     8
`define AUX_COUNT        48
`define STUFF_MAX        4
`define FRAME_NOM_1P     13920
`define FRAME_NOM_2P     7008
`define PHASE_UI         2
`define CNT_W            14
`endif

// ==== logic/frame_sync_finder.v ====
`include "frame_defines.vh"
module frame_sync_finder (
  input  wire                 mclk,
  input  wire                 rst_n,
  input  wire                 bit_en,
  input  wire                 bit_in,
  output reg                  sync_hit
);
  reg [`SYNC_LEN-1:0] shift;
  always @(posedge mclk) begin
    if (!rst_n) begin
      shift    <= {`SYNC_LEN{1'b0}};
      sync_hit <= 1'b0;
    end else begin
      sync_hit <= 1'b0;
      if (bit_en) begin
        shift    <= {shift[`SYNC_LEN-2:0], bit_in};
        sync_hit <= ({shift[`SYNC_LEN-2:0], bit_in} == `SYNC_WORD); // RULE_10
      end
    end
  end
endmodule

// ==== testbench/frame_mux_sva.sv ====
// ---
// Port checker
// ---
module frame_mux_sva (
  input wire        mclk,
  input wire        rst_n,
  input wire        two_pair,
  input wire        bit_en,
  input wire        core_ready,
  input wire        tx_bit,
  input wire        tx_frame_start,
  input wire        rx_core_valid,
  input wire        rx_aux_valid,
  input wire        rx_oh_valid,
  input wire [5:0]  rx_oh_index,
  input wire [13:0] rx_frame_len,
  input wire        rx_len_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_idle; $rose(rst_n) |-> tx_bit && !tx_frame_start && !rx_len_valid; endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_core; core_ready |-> bit_en; endproperty
  a_core: assert property (p_core) else $error("core without bit");
  property p_hold; !bit_en |=> $stable(tx_bit); endproperty
  a_hold: assert property (p_hold) else $error("tx bit moved");
  property p_start; tx_frame_start |-> $past(bit_en); endproperty
  a_start: assert property (p_start) else $error("start without bit");
  property p_kind; $onehot0({rx_core_valid, rx_aux_valid, rx_oh_valid}); endproperty
  a_kind: assert property (p_kind) else $error("two kinds at once");
  property p_aux; rx_aux_valid |=> !rx_aux_valid [*8]; endproperty
  a_aux: assert property (p_aux) else $error("aux too close");
  property p_oh; rx_oh_valid |-> rx_oh_index >= 6'h0E && rx_oh_index <= 6'h2D; endproperty
  a_oh: assert property (p_oh) else $error("oh index");
  property p_len;
    rx_len_valid |-> (two_pair ? rx_frame_len inside {14'h1B5E, 14'h1B60, 14'h1B62}
                               : rx_frame_len inside {14'h365E, 14'h3660, 14'h3662});
  endproperty
  a_len: assert property (p_len) else $error("frame length");
  c_start: cover property (tx_frame_start);
  c_long: cover property (rx_len_valid && rx_frame_len == 14'h1B62);
  c_short: cover property (rx_len_valid && rx_frame_len == 14'h1B5E);
endmodule
bind dsl_frame_mux_demux frame_mux_sva frame_mux_sva_i (.mclk, .rst_n, .two_pair, .bit_en,
  .core_ready, .tx_bit, .tx_frame_start, .rx_core_valid, .rx_aux_valid, .rx_oh_valid,
  .rx_oh_index, .rx_frame_len, .rx_len_valid);

// ==== testbench/far_end_model.sv ====
// ---
// Remote end, sends back every frame bit
// ---
module far_end_model (
  input  wire  mclk,
  input  wire  bit_en,
  input  wire  tx_bit,
  output logic rx_line_bit = 0,
  output logic rx_bit_en = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_d = 0;
  logic hold = 0;
  // The line holds a bit two cycles, then flips so a late sample is caught.
  always @(posedge mclk) begin
    en_d <= bit_en;
    rx_bit_en <= en_d;
    if (en_d) begin
      rx_line_bit <= tx_bit;
      hold <= 1;
    end else if (hold) begin
      hold <= 0;
    end else begin
      rx_line_bit <= ~rx_line_bit;
    end
  end
endmodule

// ==== testbench/dsl_frame_mux_demux_bench.sv ====
`include "frame_defines.vh"
// ---
// Loopback bench
// ---
module dsl_frame_mux_demux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 0, rst_n = 0, two_pair = 1, customer_side = 0;
  logic              bit_en = 0, core_bit = 0, bit_d = 0;
  logic [47:0]       aux_tx = 48'hF00F_5A3C_C300;
  logic [45:0]       oh_tx = 46'h1234_5678_9ABC;
  logic signed [7:0] phase_err = 8'sh02;
  wire               core_ready, tx_bit, tx_frame_start, rx_line_bit, rx_bit_en;
  wire               rx_core_bit, rx_core_valid, rx_aux_bit, rx_aux_valid;
  wire               rx_oh_bit, rx_oh_valid, rx_len_valid;
  wire [5:0]         rx_aux_index, rx_oh_index;
  wire [13:0]        rx_frame_len;
  int                miscompares = 0, cmp_count = 0, cyc = 0, pos = 0, nfr = 0, nrx = 0;
  int                exp_len = `FRAME_NOM_2P;
  int                lens[$];
  logic              q[$];
  logic              rq[$];
  dsl_frame_mux_demux dsl_frame_mux_demux_i (.mclk, .rst_n, .two_pair, .customer_side,
    .bit_en, .core_bit, .core_ready, .aux_tx, .oh_tx, .phase_err, .tx_bit, .tx_frame_start,
    .rx_line_bit, .rx_bit_en, .rx_core_bit, .rx_core_valid, .rx_aux_bit, .rx_aux_valid,
    .rx_aux_index, .rx_oh_bit, .rx_oh_valid, .rx_oh_index, .rx_frame_len, .rx_len_valid);
  far_end_model far_end_model_i (.mclk, .bit_en, .tx_bit, .rx_line_bit, .rx_bit_en);
  function automatic int ohv(int i);
    return i > 45 || ((i == 22 || i == 23) && !customer_side) ? 1 : oh_tx[i];
  endfunction
  function automatic int auxv(int n);
    return n < 8 ? 1 : aux_tx[n];
  endfunction
  // Returns 2 where a core bit belongs.
  function automatic int expb(int p);
    int b;
    b = 16;
    if (p < 14) return (`SYNC_WORD >> (13 - p)) & 1;
    if (p < 16) return ohv(p);
    p -= 16;
    for (int g = 0; g < 4; g++) begin
      if (p < `BLOCK_LEN_2P * 12) return p % `BLOCK_LEN_2P ? 2 : auxv(g * 12 + p / 145);
      p -= `BLOCK_LEN_2P * 12;
      if (g < 3 && p < 10) return ohv(b + p);
      p -= 10;
      b += 10;
    end
    return 1;
  endfunction
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t: got %0d, expected %0d", $time, got, exp);
    end
  endtask
  task final_report;
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #5 mclk = ~mclk;
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    wait (nfr == 4);
    repeat (40) @(posedge mclk);
    chk(14'(nrx > 1), 14'h1);
    final_report;
  end
  // Spacing of three cycles lets the receive synchroniser see every bit.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      final_report;
    end
    bit_en <= rst_n && cyc % 3 == 0;
    bit_d <= bit_en;
    if (bit_en && core_ready) begin
      q.push_back(core_bit);
      rq.push_back(core_bit);
      core_bit <= q.size() % 3 == 1;
    end
    // The frame start flag stands beside the last bit of the finished frame.
    if (bit_d && nfr > 0) begin
      if (expb(pos) == 2) chk(14'(tx_bit), 14'(q.pop_front()));
      else chk(14'(tx_bit), 14'(expb(pos)));
      pos++;
    end
    if (bit_d && tx_frame_start) begin
      if (nfr > 0) chk(14'(pos), 14'(exp_len));
      if (nfr > 0) chk(14'(q.size()), 14'h0);
      lens.push_back(exp_len);
      q.delete();
      exp_len = phase_err > 2 ? `FRAME_NOM_2P + 2 : phase_err < -2 ? `FRAME_NOM_2P - 2
                                                                  : `FRAME_NOM_2P;
      phase_err <= nfr == 0 ? 8'sh03 : 8'shFD;
      customer_side <= nfr > 1;
      nfr++;
      pos = 0;
    end
    if (rx_core_valid) chk(14'(rx_core_bit), 14'(rq.pop_front()));
    if (rx_len_valid) begin
      chk(rx_frame_len, 14'(lens.pop_front()));
      nrx++;
    end
    if (rx_aux_valid) chk(14'(rx_aux_bit), 14'(auxv(rx_aux_index)));
    if (rx_oh_valid && rx_oh_index > 13) chk(14'(rx_oh_bit), 14'(ohv(rx_oh_index)));
  end
endmodule
